// file: rtl/bce_pkg.sv
/*
 Constants and types for the binary encoder block.
 Assumes one controller clock; one logic cycle is one enabled clock edge.
*/
package bce_pkg;

    // ========================================
    // Sizes
    localparam int BCE_MAX_IN = 8;
    localparam int BCE_CODE_W = 3;

    // ========================================
    // Reset values
    localparam logic [BCE_CODE_W-1:0] BCE_CODE_RST = 3'h0;
    localparam logic BCE_ERR_RST = 1'b0;

    // ========================================
    // Coding modes
    typedef enum logic [2:0] {
        BCE_MODE_PEAK = 3'h1,
        BCE_MODE_GREATEST = 3'h2,
        BCE_MODE_DOMINANT = 3'h4
    } bce_mode_t;

endpackage

// file: rtl/bce_core.sv
/*
 Combinational encoder core: inputs and mode in, code and error out.
 Assumes inputs above the configured count are already masked to zero.
*/
`timescale 1ns/1ps
module bce_core
    import bce_pkg::*;
(
    input wire logic [BCE_MAX_IN-1:0] in_i,
    input wire bce_mode_t mode_i,
    output logic [BCE_CODE_W-1:0] code_o,
    output logic err_o
);

    // ========================================
    // Helpers
    function automatic logic [BCE_CODE_W-1:0] bce_top_index(input logic [BCE_MAX_IN-1:0] v);
        logic [BCE_CODE_W-1:0] idx;
        idx = BCE_CODE_RST;
        for (int k = 0; k < BCE_MAX_IN; k++)
        begin
            if (v[k])
            begin
                idx = k[BCE_CODE_W-1:0];
            end
        end
        return idx;
    endfunction

    function automatic logic bce_is_one_hot(input logic [BCE_MAX_IN-1:0] v);
        return (v != '0) && ((v & (v - 1'b1)) == '0);
    endfunction

    always_comb
    begin
        code_o = BCE_CODE_RST;
        err_o = 1'b0;
        unique case (mode_i)
            BCE_MODE_PEAK:
            begin
                if (bce_is_one_hot(in_i))
                begin
                    code_o = bce_top_index(in_i);
                end
                else
                begin
                    err_o = 1'b1;
                end
            end
            BCE_MODE_GREATEST:
            begin
                code_o = bce_top_index(in_i);
                err_o = (in_i == '0);
            end
            BCE_MODE_DOMINANT:
            begin
                if (in_i[0])
                begin
                    code_o = BCE_CODE_RST;
                end
                else
                begin
                    code_o = bce_top_index(in_i);
                    err_o = (in_i == '0);
                end
            end
            default:
            begin
                code_o = BCE_CODE_RST;
                err_o = 1'b1;
            end
        endcase
    end

endmodule

// file: rtl/bce_encoder.sv
/*
 Top of the binary encoder: masks unused inputs, registers code and error.
 Assumes inputs and configuration come from logic on mclk_i.
*/
`timescale 1ns/1ps
module bce_encoder
    import bce_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [3:0] in_count_i,
    input wire bce_mode_t mode_i,
    input wire logic err_en_i,
    input wire logic [BCE_MAX_IN-1:0] in_i,
    output logic [BCE_CODE_W-1:0] code_o,
    output logic [BCE_CODE_W-1:0] code_width_o,
    output logic err_o
);

    // ========================================
    // State
    typedef struct packed {
        logic [BCE_CODE_W-1:0] code;
        logic err;
    } bce_state_t;

    bce_state_t st;
    bce_state_t next_st;
    logic [BCE_MAX_IN-1:0] in_mask;
    logic [BCE_MAX_IN-1:0] in_used;
    logic [BCE_CODE_W-1:0] core_code;
    logic core_err;
    logic [3:0] cnt_clamp;

    // ========================================
    // Input count and output width
    always_comb
    begin
        if (in_count_i < 4'h2)
        begin
            cnt_clamp = 4'h2;
        end
        else if (in_count_i > 4'h8)
        begin
            cnt_clamp = 4'h8;
        end
        else
        begin
            cnt_clamp = in_count_i;
        end
        in_mask = '0;
        for (int k = 0; k < BCE_MAX_IN; k++)
        begin
            in_mask[k] = (4'(k) < cnt_clamp);
        end
        if (cnt_clamp <= 4'h2)
        begin
            code_width_o = 3'h1;
        end
        else if (cnt_clamp <= 4'h4)
        begin
            code_width_o = 3'h2;
        end
        else
        begin
            code_width_o = 3'h3;
        end
    end

    assign in_used = in_i & in_mask;

    bce_core u_core (
        .in_i(in_used),
        .mode_i(mode_i),
        .code_o(core_code),
        .err_o(core_err)
    );

    always_comb
    begin
        next_st = st;
        if (ce_i)
        begin
            next_st.code = core_code;
            next_st.err = core_err & err_en_i;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st <= '{code: BCE_CODE_RST, err: BCE_ERR_RST};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign code_o = st.code;
    assign err_o = st.err;

    // ========================================
    // Checks
    AST_ZERO_ERR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && in_used == '0 && err_en_i |=> err_o && code_o == 3'h0)
        else $error("empty input must flag error");

    AST_DOM: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_DOMINANT && in_i[0] |=> code_o == 3'h0 && !err_o)
        else $error("first input dominance broken");

    // Error follows the enable of the cycle that was taken
    AST_PEAK_MULTI: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_PEAK && $countones(in_used) > 1
        |=> code_o == 3'h0 && err_o == $past(err_en_i))
        else $error("peak multi-hot must clear code");

    AST_PEAK_ONE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_PEAK && $onehot(in_used) |=> !err_o)
        else $error("peak one-hot must not flag");

    AST_TOP8: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_GREATEST && in_used[7] |=> code_o == 3'h7)
        else $error("input eight must give seven");

    AST_NO_ERR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && !err_en_i |=> !err_o)
        else $error("error indicator must stay low when omitted");

    AST_HOLD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !ce_i |=> $stable(code_o) && $stable(err_o))
        else $error("state must hold while disabled");

    AST_FIRST: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_GREATEST && in_used == 8'h01 |=> code_o == 3'h0 && !err_o)
        else $error("first input must give zero code");

    // ========================================
    // Taken cycles, answered at the next clock edge, enabled or not
    sequence bce_take_peak_one;
        ce_i && mode_i == BCE_MODE_PEAK && $onehot(in_used);
    endsequence

    sequence bce_take_greatest;
        ce_i && mode_i == BCE_MODE_GREATEST && in_used != '0;
    endsequence

    sequence bce_take_dom_low;
        ce_i && mode_i == BCE_MODE_DOMINANT && !in_used[0] && in_used != '0;
    endsequence

    sequence bce_take_narrow;
        ce_i && in_count_i < 4'h3;
    endsequence

    // Code points back at the single active input
    AST_PEAK_CODE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        bce_take_peak_one |=> $past(in_used) == (8'h01 << code_o))
        else $error("peak code must name the active input");

    // Shifting by the code leaves only the top active input
    AST_GREAT_CODE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        bce_take_greatest |=> ($past(in_used) >> code_o) == 8'h01 && !err_o)
        else $error("greatest code must name the top input");

    AST_DOM_CODE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        bce_take_dom_low |=> ($past(in_used) >> code_o) == 8'h01 && !err_o)
        else $error("dominant mode must act as greatest when first is low");

    AST_PEAK_EMPTY: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_PEAK && in_used == '0 |=> code_o == 3'h0)
        else $error("peak empty input must clear code");

    AST_GREAT_EMPTY: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_GREATEST && in_used == '0 && err_en_i |=> err_o)
        else $error("greatest empty input must flag error");

    AST_DOM_EMPTY: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_DOMINANT && in_used == '0 && err_en_i |=> err_o)
        else $error("dominant empty input must flag error");

    AST_ERR_LOW_CODE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        err_o |-> code_o == 3'h0)
        else $error("error must come with a zero code");

    AST_WEIGHT_FOUR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_GREATEST && in_used[7:4] == 4'h1 |=> code_o == 3'h4)
        else $error("input five must set only the weight four bit");

    AST_WEIGHT_TWO: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_i == BCE_MODE_GREATEST && in_used[7:2] == 6'h01 |=> code_o == 3'h2)
        else $error("input three must set only the weight two bit");

    // Counts below two behave as two
    AST_NARROW: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        bce_take_narrow |=> code_o <= 3'h1)
        else $error("two inputs must give a one bit code");

    // Counts above eight behave as eight
    AST_WIDE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && in_count_i > 4'h8 && mode_i == BCE_MODE_GREATEST && in_i[7] |=> code_o == 3'h7)
        else $error("large count must keep input eight");

    AST_FITS_WIDTH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i |=> (code_o >> $past(code_width_o)) == 3'h0)
        else $error("code must fit the reported width");

    AST_WIDTH_ONE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        in_count_i <= 4'h2 |-> code_width_o == 3'h1)
        else $error("two inputs need one output");

    AST_WIDTH_TWO: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        in_count_i inside {4'h3, 4'h4} |-> code_width_o == 3'h2)
        else $error("three or four inputs need two outputs");

    AST_WIDTH_THREE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        in_count_i > 4'h4 |-> code_width_o == 3'h3)
        else $error("five or more inputs need three outputs");

endmodule

// file: verif/bce_src.sv
/*
 Source of encoder inputs, standing in for the surrounding logic.
 Assumes the bench calls put just after a rising edge of mclk_i.
*/
`timescale 1ns/1ps
module bce_src
(
    output logic [7:0] in_o
);
    initial in_o = 8'h00;
    // New inputs land with the bench's other inputs
    task automatic put(input logic [7:0] v);
        in_o <= v;
    endtask
endmodule

// file: verif/tb_bce_encoder.sv
/*
 Self-checking bench for the binary encoder.
 Assumes the encoder answers one enabled edge after sampling.
*/
`timescale 1ns/1ps
module tb_bce_encoder;
    import bce_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b0;
    logic [3:0] in_count_i = 4'h8;
    bce_mode_t mode_i = BCE_MODE_PEAK;
    logic err_en_i = 1'b1;
    logic [BCE_MAX_IN-1:0] in_i;
    logic [BCE_CODE_W-1:0] code_o;
    logic [BCE_CODE_W-1:0] code_width_o;
    logic err_o;
    logic [3:0] exp_q = 4'h0;
    int failures = 0;
    int compares = 0;
    int seed = 13250;
    always #25 mclk_i = ~mclk_i;
    bce_src src (.in_o(in_i));
    bce_encoder dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .in_count_i(in_count_i), .mode_i(mode_i), .err_en_i(err_en_i),
        .in_i(in_i), .code_o(code_o), .code_width_o(code_width_o), .err_o(err_o));
    // ========================================
    // Expected {error, code}
    function automatic logic [3:0] ref_of(bce_mode_t m, logic [3:0] c, logic e,
        logic [7:0] v);
        int n;
        int hi;
        logic [7:0] s;
        n = (c < 2) ? 2 : ((c > 8) ? 8 : c);
        s = v & ((8'h01 << n) - 8'h01);
        hi = -1;
        for (int i = 0; i < 8; i++)
            if (s[i])
                hi = i;
        if (m == BCE_MODE_DOMINANT && s[0])
            return 4'h0;
        if (s == 8'h00 || !(m inside {BCE_MODE_PEAK, BCE_MODE_GREATEST, BCE_MODE_DOMINANT})
            || (m == BCE_MODE_PEAK && $countones(s) > 1))
            return {e, 3'h0};
        return {1'b0, 3'(hi)};
    endfunction
    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        compares++;
        if (seen !== want)
        begin
            failures++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic step(input logic [2:0] m, input logic [3:0] c, input logic e,
        input logic [7:0] v, input logic en);
        int w;
        @(posedge mclk_i);
        ce_i <= en;
        mode_i <= bce_mode_t'(m);
        in_count_i <= c;
        err_en_i <= e;
        src.put(v);
        #1;
        check({err_o, code_o}, exp_q);
        w = (c <= 2) ? 1 : ((c <= 4) ? 2 : 3);
        check({1'b0, code_width_o}, 4'(w));
        if (en)
            exp_q = ref_of(bce_mode_t'(m), c, e, v);
    endtask
    task automatic summarize();
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ========================================
    // Corner cases, then random traffic
    initial
    begin
        int r;
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            for (int i = 0; i < 8; i++)
                step(3'h1 << m, 4'h8, 1'b1, 8'h01 << i, 1'b1);
            step(3'h1 << m, 4'h8, 1'b1, 8'h00, 1'b1);
            step(3'h1 << m, 4'h8, 1'b1, 8'h81, 1'b1);
            step(3'h1 << m, 4'h2, 1'b1, 8'hfc, 1'b1);
            step(3'h1 << m, 4'h2, 1'b1, 8'h03, 1'b1);
            step(3'h1 << m, 4'h5, 1'b0, 8'h00, 1'b1);
            step(3'h1 << m, 4'h0, 1'b1, 8'h06, 1'b1);
        end
        step(3'h3, 4'h8, 1'b1, 8'h10, 1'b1);
        for (int k = 0; k < 400; k++)
        begin
            r = $random(seed);
            step(r[2:0] == 3'h0 ? 3'h6 : 3'h1 << (r[4:3] % 3), r[8:5], r[9] | r[10],
                r[18:11], r[19] | r[20]);
        end
        // Leave a non-zero code standing so the reset has something to clear
        step(3'h2, 4'h8, 1'b1, 8'h80, 1'b1);
        step(3'h2, 4'h8, 1'b1, 8'h80, 1'b0);
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        exp_q = 4'h0;
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        step(3'h2, 4'h8, 1'b1, 8'h40, 1'b1);
        step(3'h2, 4'h8, 1'b1, 8'h00, 1'b0);
        summarize();
    end
endmodule
